// file: hdl/dtt_debug_trigger_trace.sv
/*
 * Debug trigger and trace registers: force reset, comparators, trace FIFO and control.
 * Assumes the register request and CPU cycle inputs are synchronous to ref_clk.
 */
`timescale 1ns/1ns
module dtt_debug_trigger_trace
    import dtt_pkg::*;
#(
    parameter int unsigned DEPTH = FIFO_DEPTH,
    parameter int unsigned AW = CPU_AW
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic srst,
    // Register access from the CPU or a background debug command.
    input wire dtt_reg_req_s reg_req,
    output logic [7:0] reg_rdata_q,
    // Observed CPU bus cycle and opcode tracking.
    input wire dtt_cpu_cycle_s cpu_cycle,
    input wire logic [AW-1:0] last_opcode_addr,
    input wire logic mcu_secure,
    // Trigger setup held outside this block.
    input wire logic [3:0] trigger_mode,
    input wire logic begin_trace,
    input wire logic trigger_qualify_select,
    // Results.
    output logic mcu_reset_req_q,
    output logic break_req_q,
    output logic break_tag_q,
    output logic run_active_flag,
    output logic [$clog2(DEPTH+1)-1:0] valid_count_q
);
    localparam int unsigned CW = $clog2(DEPTH+1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

    logic [7:0] cmp_a_high_q;
    logic [7:0] cmp_a_low_q;
    logic [7:0] cmp_b_high_q;
    logic [7:0] cmp_b_low_q;
    logic [7:0] control_q;
    logic [15:0] fifo_q [DEPTH];
    dtt_run_e run_q;
    logic a_seen_q;
    logic [AW-1:0] cmp_a;
    logic [AW-1:0] cmp_b;
    logic wr_cmp_ok;
    logic wr_ctl;
    logic rd_low;
    logic event_only;
    logic dir_a_ok;
    logic dir_b_ok;
    logic hit_a;
    logic hit_b;
    logic trig;
    logic store_ev;
    logic [15:0] store_word;
    logic shift_en;
    logic [15:0] shift_word;
    logic full_next;
    logic run_done;
    logic arm_start;
    logic manual_stop;

    assign cmp_a = {cmp_a_high_q, cmp_a_low_q};
    assign cmp_b = {cmp_b_high_q, cmp_b_low_q};
    assign wr_cmp_ok = reg_req.wr && !control_q[CTL_ARM];
    assign wr_ctl = reg_req.wr && reg_req.addr == OFS_CONTROL;
    assign rd_low = reg_req.rd && reg_req.addr == OFS_FIFO_LOW;
    assign event_only = trigger_mode == TRG_EVENT_B
        || trigger_mode == TRG_A_THEN_EVENT_B;
    assign run_active_flag = control_q[CTL_ARM];

    // A direction-qualified comparator ignores R/W unless its enable is set.
    assign dir_a_ok = !control_q[CTL_CMP_A_DIRECTION_ENABLE]
        || (cpu_cycle.rnw == control_q[CTL_RWA]);
    assign dir_b_ok = !control_q[CTL_CMP_B_DIRECTION_ENABLE]
        || (cpu_cycle.rnw == control_q[CTL_RWB]);

    // Tag qualification only gates matches, so break timing stays the same.
    always_comb begin
        hit_a = cpu_cycle.valid && cpu_cycle.addr == cmp_a && dir_a_ok
            && (!trigger_qualify_select || cpu_cycle.exec);
        hit_b = cpu_cycle.valid && cpu_cycle.addr == cmp_b && dir_b_ok
            && (!trigger_qualify_select || cpu_cycle.exec);
        trig = 1'b0;
        case (trigger_mode)
            TRG_A_ONLY: trig = hit_a;
            TRG_A_OR_B: trig = hit_a || hit_b;
            TRG_A_THEN_B: trig = a_seen_q && hit_b;
            TRG_A_AND_B_DATA: trig = hit_a && cpu_cycle.data == cmp_b_low_q;
            TRG_A_AND_NOT_B: trig = hit_a && cpu_cycle.data != cmp_b_low_q;
            TRG_INSIDE: begin
                trig = cpu_cycle.valid && dir_a_ok
                    && cpu_cycle.addr >= cmp_a && cpu_cycle.addr <= cmp_b;
            end
            TRG_OUTSIDE: begin
                trig = cpu_cycle.valid && dir_a_ok
                    && (cpu_cycle.addr < cmp_a || cpu_cycle.addr > cmp_b);
            end
            default: trig = 1'b0;
        endcase
    end

    // Event-only modes keep the upper half of each word empty.
    always_comb begin
        store_ev = 1'b0;
        store_word = {cpu_cycle.addr[15:0]};
        if (event_only) begin
            store_ev = run_q == DTT_STORE && hit_b
                && (trigger_mode == TRG_EVENT_B || a_seen_q);
            store_word = {8'h00, cpu_cycle.data};
        end else begin
            store_ev = run_q == DTT_STORE && cpu_cycle.valid && cpu_cycle.cof;
        end
    end

    assign full_next = store_ev && (valid_count_q == CNT_FULL - CW'(1)
        || valid_count_q == CNT_FULL);
    always_comb begin
        run_done = 1'b0;
        if (run_q == DTT_STORE) begin
            if (event_only || begin_trace) begin
                run_done = full_next;
            end else begin
                run_done = trig;
            end
        end
    end

    assign arm_start = wr_ctl && reg_req.wdata[CTL_ARM]
        && reg_req.wdata[CTL_ENABLE] && !mcu_secure;
    assign manual_stop = wr_ctl && !arm_start;

    // Armed reads must not disturb capture, so only unarmed reads shift.
    assign shift_en = store_ev || (rd_low && !control_q[CTL_ARM]);
    assign shift_word = store_ev ? store_word : 16'(last_opcode_addr);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cmp_a_high_q <= BYTE_RESET;
            cmp_a_low_q <= BYTE_RESET;
            cmp_b_high_q <= BYTE_RESET;
            cmp_b_low_q <= BYTE_RESET;
        end else if (wr_cmp_ok) begin
            if (reg_req.addr == OFS_CMP_A_HIGH) begin
                cmp_a_high_q <= reg_req.wdata;
            end else if (reg_req.addr == OFS_CMP_A_LOW) begin
                cmp_a_low_q <= reg_req.wdata;
            end else if (reg_req.addr == OFS_CMP_B_HIGH) begin
                cmp_b_high_q <= reg_req.wdata;
            end else if (reg_req.addr == OFS_CMP_B_LOW) begin
                cmp_b_low_q <= reg_req.wdata;
            end
        end
    end

    // A write that starts a run wins over a completion in the same cycle.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            control_q <= CONTROL_RESET;
        end else if (wr_ctl) begin
            control_q <= reg_req.wdata;
            control_q[CTL_ENABLE] <= reg_req.wdata[CTL_ENABLE] && !mcu_secure;
            control_q[CTL_ARM] <= arm_start;
        end else if (run_done) begin
            control_q[CTL_ARM] <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            run_q <= DTT_IDLE;
        end else if (arm_start) begin
            run_q <= (begin_trace && !event_only) ? DTT_WAIT : DTT_STORE;
        end else if (manual_stop || run_done) begin
            run_q <= DTT_IDLE;
        end else begin
            case (run_q)
                DTT_WAIT: begin
                    if (trig) begin
                        run_q <= DTT_STORE;
                    end
                end
                default: run_q <= run_q;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            a_seen_q <= 1'b0;
        end else if (arm_start) begin
            a_seen_q <= 1'b0;
        end else if (run_q != DTT_IDLE && hit_a) begin
            a_seen_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            valid_count_q <= '0;
        end else if (arm_start) begin
            valid_count_q <= '0;
        end else if (store_ev && valid_count_q != CNT_FULL) begin
            valid_count_q <= valid_count_q + CW'(1);
        end
    end

    // Shift register: the head is read, new words enter at the tail.
    for (genvar i = 0; i < DEPTH; i++) begin : g_fifo
        always_ff @(posedge ref_clk) begin
            if (srst) begin
                fifo_q[i] <= 16'h0000;
            end else if (shift_en) begin
                if (i == DEPTH - 1) begin
                    fifo_q[i] <= shift_word;
                end else begin
                    fifo_q[i] <= fifo_q[i+1];
                end
            end
        end
    end

    // Read data is registered; the FIFO head is sampled before it shifts.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_req.rd) begin
            if (reg_req.addr == OFS_FORCE_RESET) begin
                reg_rdata_q <= 8'h00;
            end else if (reg_req.addr == OFS_CMP_A_HIGH) begin
                reg_rdata_q <= cmp_a_high_q;
            end else if (reg_req.addr == OFS_CMP_A_LOW) begin
                reg_rdata_q <= cmp_a_low_q;
            end else if (reg_req.addr == OFS_CMP_B_HIGH) begin
                reg_rdata_q <= cmp_b_high_q;
            end else if (reg_req.addr == OFS_CMP_B_LOW) begin
                reg_rdata_q <= cmp_b_low_q;
            end else if (reg_req.addr == OFS_FIFO_HIGH) begin
                reg_rdata_q <= event_only ? 8'h00 : fifo_q[0][15:8];
            end else if (reg_req.addr == OFS_FIFO_LOW) begin
                reg_rdata_q <= fifo_q[0][7:0];
            end else if (reg_req.addr == OFS_CONTROL) begin
                reg_rdata_q <= control_q;
            end else begin
                reg_rdata_q <= 8'h00;
            end
        end
    end

    // The request is never held, so a reset of this block cannot re-fire it.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mcu_reset_req_q <= 1'b0;
        end else begin
            mcu_reset_req_q <= reg_req.wr && reg_req.dbg_cmd
                && reg_req.addr == OFS_FORCE_RESET
                && reg_req.wdata[FORCE_RESET_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            break_req_q <= 1'b0;
            break_tag_q <= 1'b0;
        end else begin
            break_req_q <= control_q[CTL_BREAK_REQUEST_ENABLE] && run_done && !wr_ctl;
            break_tag_q <= control_q[CTL_TAG];
        end
    end
endmodule

// file: hdl/dtt_pkg.sv
/*
 * Constants, field positions and carrier types for the debug trigger and trace block.
 * Assumes one bus clock and a synchronous active-high MCU reset.
 */
// Operation
// - Force-reset register ignores user program writes.
// - Force-reset register always reads zero.
// - Debug-command write of bit 0 resets MCU.
// - Byte registers for comparators, FIFO, control.
// - Comparator bytes reset zero, writable only unarmed.
// - FIFO high byte read-only, zero in event modes.
// - FIFO high read does not advance FIFO.
// - FIFO low read returns low, then advances.
// - Event-only modes store 8-bit data only.
// - Low reads while armed never advance FIFO.
// - Unarmed low read stores last opcode address.
// - FIFO eight deep; ninth read returns first.
// - Enable bit refuses setting while MCU secure.
// - Arm bit starts run, self-clears, manual stop.
// - Bit 5 picks force or tag break.
// - Break on end trigger or begin-trace full.
// - Break timing ignores trigger qualify select.
// - Comparator A direction qualifier bits 3 and 2.
// - Comparator B direction qualifier bits 1 and 0.
// - Control register accessible at any time.
// - Run ends on full or end trigger.
// - Codes 0011 and 0100 are event-only modes.
package dtt_pkg;
    localparam int unsigned REG_AW = 4;
    localparam int unsigned CPU_AW = 16;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam logic [3:0] OFS_FORCE_RESET = 4'h0;
    localparam logic [3:0] OFS_CMP_A_HIGH = 4'h1;
    localparam logic [3:0] OFS_CMP_A_LOW = 4'h2;
    localparam logic [3:0] OFS_CMP_B_HIGH = 4'h3;
    localparam logic [3:0] OFS_CMP_B_LOW = 4'h4;
    localparam logic [3:0] OFS_FIFO_HIGH = 4'h5;
    localparam logic [3:0] OFS_FIFO_LOW = 4'h6;
    localparam logic [3:0] OFS_CONTROL = 4'h7;
    localparam int unsigned FORCE_RESET_BIT = 0;
    localparam int unsigned CTL_ENABLE = 7;
    localparam int unsigned CTL_ARM = 6;
    localparam int unsigned CTL_TAG = 5;
    localparam int unsigned CTL_BREAK_REQUEST_ENABLE = 4;
    localparam int unsigned CTL_RWA = 3;
    localparam int unsigned CTL_CMP_A_DIRECTION_ENABLE = 2;
    localparam int unsigned CTL_RWB = 1;
    localparam int unsigned CTL_CMP_B_DIRECTION_ENABLE = 0;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [3:0] TRG_A_ONLY = 4'h0;
    localparam logic [3:0] TRG_A_OR_B = 4'h1;
    localparam logic [3:0] TRG_A_THEN_B = 4'h2;
    localparam logic [3:0] TRG_EVENT_B = 4'h3;
    localparam logic [3:0] TRG_A_THEN_EVENT_B = 4'h4;
    localparam logic [3:0] TRG_A_AND_B_DATA = 4'h5;
    localparam logic [3:0] TRG_A_AND_NOT_B = 4'h6;
    localparam logic [3:0] TRG_INSIDE = 4'h7;
    localparam logic [3:0] TRG_OUTSIDE = 4'h8;

    typedef enum logic [2:0] {
        DTT_IDLE = 3'b001,
        DTT_WAIT = 3'b010,
        DTT_STORE = 3'b100
    } dtt_run_e;

    typedef struct packed {
        logic rd;
        logic wr;
        logic dbg_cmd;
        logic [REG_AW-1:0] addr;
        logic [7:0] wdata;
    } dtt_reg_req_s;

    typedef struct packed {
        logic valid;
        logic rnw;
        logic exec;
        logic cof;
        logic [CPU_AW-1:0] addr;
        logic [7:0] data;
    } dtt_cpu_cycle_s;
endpackage

// file: tb/dtt_debug_trigger_trace_asserts.sv
/* Assertion checker for the debug trigger and trace block.
   Assumes it is bound to dtt_debug_trigger_trace and sees only its ports. */
`timescale 1ns/1ns
module dtt_asserts
    import dtt_pkg::*;
#(
    parameter int unsigned DEPTH = FIFO_DEPTH
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic srst,
    // Watched ports.
    input wire dtt_reg_req_s reg_req,
    input wire logic [7:0] reg_rdata_q,
    input wire logic mcu_secure,
    input wire logic mcu_reset_req_q,
    input wire logic break_req_q,
    input wire logic break_tag_q,
    input wire logic run_active_flag,
    input wire logic [$clog2(DEPTH+1)-1:0] valid_count_q
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    logic fw;
    logic cw;
    assign fw = reg_req.wr && reg_req.addr == OFS_FORCE_RESET;
    assign cw = reg_req.wr && reg_req.addr == OFS_CONTROL;
    a_fr_user_ignored: assert property (fw && !reg_req.dbg_cmd |=> !mcu_reset_req_q)
        else $error("user write caused reset");
    a_fr_read_zero: assert property (reg_req.rd && reg_req.addr == OFS_FORCE_RESET |=> reg_rdata_q == 8'h00)
        else $error("force reset read not zero");
    a_fr_pulse: assert property (fw && reg_req.dbg_cmd && reg_req.wdata[0] |=> mcu_reset_req_q)
        else $error("reset request missing");
    a_fr_cause: assert property (mcu_reset_req_q |-> $past(fw && reg_req.dbg_cmd && reg_req.wdata[0]))
        else $error("reset request without cause");
    a_secure_no_run: assert property (cw && mcu_secure |=> !run_active_flag)
        else $error("armed while secure");
    a_arm_start: assert property (cw && reg_req.wdata[7:6] == 2'b11 && !mcu_secure |=> run_active_flag && valid_count_q == 0)
        else $error("run did not start");
    a_manual_stop: assert property (cw && !(reg_req.wdata[7] && reg_req.wdata[6]) |=> !run_active_flag)
        else $error("run not stopped");
    a_brk_ends_run: assert property (break_req_q |-> !run_active_flag && $past(run_active_flag) ##1 !break_req_q)
        else $error("break not tied to run end");
    a_tag_copy: assert property (cw |=> ##1 break_tag_q == $past(reg_req.wdata[5], 2))
        else $error("tag select not followed");
endmodule
bind dtt_debug_trigger_trace dtt_asserts #(.DEPTH(DEPTH)) u_chk (.ref_clk(ref_clk), .srst(srst),
    .reg_req(reg_req), .reg_rdata_q(reg_rdata_q), .mcu_secure(mcu_secure),
    .mcu_reset_req_q(mcu_reset_req_q), .break_req_q(break_req_q), .break_tag_q(break_tag_q),
    .run_active_flag(run_active_flag), .valid_count_q(valid_count_q));

// file: tb/dtt_cpu_model.sv
/* CPU bus model: drives observed bus cycles and the opcode tracker.
   Assumes its tasks are called from the bench in the ref_clk domain. */
`timescale 1ns/1ns
module dtt_cpu_model
    import dtt_pkg::*;
(
    // Clock.
    input wire logic ref_clk,
    // Bus cycle and opcode address.
    output dtt_cpu_cycle_s cpu_cycle,
    output logic [CPU_AW-1:0] last_opcode_addr
);
    initial begin
        cpu_cycle = '0;
        last_opcode_addr = 16'h0000;
    end
    // Idle cycles show the inverted address, so a stale match cannot pass.
    task automatic access(input logic [15:0] a, input logic rnw);
        @(posedge ref_clk);
        #1;
        cpu_cycle = '{valid: 1'b1, rnw: rnw, exec: 1'b1, cof: 1'b0, addr: a, data: 8'h5A};
        @(posedge ref_clk);
        #1;
        cpu_cycle = '{valid: 1'b0, rnw: ~rnw, exec: 1'b0, cof: 1'b0, addr: ~a, data: 8'hA5};
    endtask
    task automatic fetch(input logic [15:0] a);
        @(posedge ref_clk);
        #1;
        last_opcode_addr = a;
    endtask
endmodule

// file: tb/tb_dtt_debug_trigger_trace.sv
/* Self-checking bench for the debug trigger and trace block.
   Assumes the CPU bus model and the bound assertion checker. */
`timescale 1ns/1ns
module tb_dtt_debug_trigger_trace
    import dtt_pkg::*;
;
    logic ref_clk;
    logic srst;
    dtt_reg_req_s reg_req;
    logic [7:0] reg_rdata_q;
    dtt_cpu_cycle_s cpu_cycle;
    logic [15:0] last_opcode_addr;
    logic mcu_secure;
    logic [3:0] trigger_mode;
    logic begin_trace;
    logic trigger_qualify_select;
    logic mcu_reset_req_q;
    logic break_req_q;
    logic break_tag_q;
    logic run_active_flag;
    logic [3:0] valid_count_q;
    int bad_count;
    int n_tests;
    logic [7:0] h;
    logic [7:0] h2;
    logic [7:0] l;
    logic got;
    dtt_debug_trigger_trace uut (.ref_clk(ref_clk), .srst(srst), .reg_req(reg_req),
        .reg_rdata_q(reg_rdata_q), .cpu_cycle(cpu_cycle), .last_opcode_addr(last_opcode_addr),
        .mcu_secure(mcu_secure), .trigger_mode(trigger_mode), .begin_trace(begin_trace),
        .trigger_qualify_select(trigger_qualify_select), .mcu_reset_req_q(mcu_reset_req_q),
        .break_req_q(break_req_q), .break_tag_q(break_tag_q),
        .run_active_flag(run_active_flag), .valid_count_q(valid_count_q));
    dtt_cpu_model cpu (.ref_clk(ref_clk), .cpu_cycle(cpu_cycle),
        .last_opcode_addr(last_opcode_addr));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic dbg);
        @(posedge ref_clk);
        #1;
        reg_req = '{rd: 1'b0, wr: 1'b1, dbg_cmd: dbg, addr: a, wdata: d};
        @(posedge ref_clk);
        #1;
        reg_req = '0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        #1;
        reg_req = '{rd: 1'b1, wr: 1'b0, dbg_cmd: 1'b0, addr: a, wdata: 8'h00};
        @(posedge ref_clk);
        #1;
        reg_req = '0;
        d = reg_rdata_q;
    endtask
    task automatic rc(input logic [3:0] a, input logic [7:0] exp);
        rd(a, l);
        chk(l, exp);
    endtask
    // A break lasts one cycle, so every cycle of the window is sampled.
    task automatic poll(input int n);
        got = 1'b0;
        repeat (n) begin
            if (break_req_q === 1'b1)
                got = 1'b1;
            @(posedge ref_clk);
            #2;
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    initial begin
        #20000;
        bad_count++;
        close_out();
    end
    initial begin
        srst = 1'b1;
        reg_req = '0;
        mcu_secure = 1'b0;
        trigger_mode = TRG_A_ONLY;
        begin_trace = 1'b0;
        trigger_qualify_select = 1'b0;
        bad_count = 0;
        n_tests = 0;
        repeat (3) @(posedge ref_clk);
        #1;
        srst = 1'b0;
        for (int i = 0; i < 16; i++) rc(4'(i), 8'h00);
        $display("reset values done");
        for (int i = 1; i < 5; i++) wr(4'(i), 8'hA0 + 8'(i), 1'b0);
        for (int i = 1; i < 5; i++) rc(4'(i), 8'hA0 + 8'(i));
        $display("comparators done");
        wr(OFS_FORCE_RESET, 8'h01, 1'b0);
        chk(8'(mcu_reset_req_q), 8'h00);
        wr(OFS_FORCE_RESET, 8'h01, 1'b1);
        chk(8'(mcu_reset_req_q), 8'h01);
        rc(OFS_FORCE_RESET, 8'h00);
        $display("force reset done");
        mcu_secure = 1'b1;
        wr(OFS_CONTROL, 8'h80, 1'b0);
        rc(OFS_CONTROL, 8'h00);
        mcu_secure = 1'b0;
        wr(OFS_CONTROL, 8'hA5, 1'b0);
        rc(OFS_CONTROL, 8'hA5);
        chk(8'(break_tag_q), 8'h01);
        $display("control done");
        wr(OFS_CONTROL, 8'hDC, 1'b0);
        rc(OFS_CONTROL, 8'hDC);
        wr(OFS_CMP_A_HIGH, 8'h55, 1'b0);
        rc(OFS_CMP_A_HIGH, 8'hA1);
        cpu.access(16'hA1A2, 1'b0);
        poll(4);
        chk(8'(got), 8'h00);
        chk(8'(run_active_flag), 8'h01);
        cpu.access(16'hA1A2, 1'b1);
        poll(6);
        chk(8'(got), 8'h01);
        chk(8'(run_active_flag), 8'h00);
        chk(8'(break_tag_q), 8'h00);
        rc(OFS_CONTROL, 8'h9C);
        $display("end trace run done");
        wr(OFS_FIFO_HIGH, 8'hFF, 1'b0);
        wr(OFS_FIFO_LOW, 8'hFF, 1'b0);
        for (int i = 0; i < 16; i++) begin
            cpu.fetch(16'h1000 + 16'(i));
            rd(OFS_FIFO_HIGH, h);
            rd(OFS_FIFO_HIGH, h2);
            rd(OFS_FIFO_LOW, l);
            chk(h2, h);
            if (i >= 8) begin
                chk(h, 8'h10);
                chk(l, 8'(i - 8));
            end
        end
        $display("profiling done");
        wr(OFS_CONTROL, 8'hC0, 1'b0);
        chk(8'(run_active_flag), 8'h01);
        wr(OFS_CONTROL, 8'h40, 1'b0);
        chk(8'(run_active_flag), 8'h00);
        $display("manual stop done");
        trigger_mode = TRG_EVENT_B;
        wr(OFS_CONTROL, 8'hC0, 1'b0);
        repeat (8) cpu.access(16'hA3A4, 1'b1);
        chk(8'(valid_count_q), 8'h08);
        chk(8'(run_active_flag), 8'h00);
        rc(OFS_FIFO_HIGH, 8'h00);
        rc(OFS_FIFO_LOW, 8'h5A);
        rc(OFS_FIFO_LOW, 8'h5A);
        $display("event only run done");
        close_out();
    end
endmodule
